// [logic/gir_top.sv]
// Purpose: interrupt generation and register unlock gating
// Assumes: host i/o strobes and events synchronous to core_clk
// Notes: read data appears one cycle after the read strobe

`timescale 1ns/1ps

module gir_top
   import gir_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic bus_is_vlb,
   input wire gir_evt_t evt,
   input wire gir_io_req_t io_req,
   output logic [15:0] io_rdata_q,
   output logic io_rvalid_q,
   output logic irq_pin_q
);

   // ==========================================================
   // access decoding helpers
   function automatic logic key1_open(input logic [7:0] k);
      key1_open = (k & GIR_KEY1_MASK) == GIR_KEY1_VAL;
   endfunction

   // whether an index may be read or written now
   function automatic logic idx_open(input logic [7:0] idx,
                                     input logic [7:0] k1,
                                     input logic [7:0] k2);
      logic k2ok;
      k2ok = (k2 == GIR_KEY2_VAL);
      if (idx == GIR_IDX_RETRACE || idx == GIR_IDX_KEY1 ||
          idx == GIR_IDX_KEY2)
         idx_open = 1'b1;
      else if (idx == GIR_IDX_STRAP_A || idx == GIR_IDX_STRAP_B ||
               idx == GIR_IDX_STRAP_C || idx >= GIR_IDX_EXT2_LO)
         idx_open = k2ok;
      else if (idx >= GIR_IDX_EXT1_LO && idx <= GIR_IDX_EXT1_HI)
         idx_open = key1_open(k1);
      else
         idx_open = 1'b0;
   endfunction

   // ==========================================================
   // register state
   logic [7:0] index_q, index_d; // index port
   logic [7:0] rctl_q, rctl_d; // retrace_control_reg
   logic [7:0] gctl_q, gctl_d; // global_irq_control_reg
   logic [7:0] key1_q, key1_d; // first_lock_key_reg
   logic [7:0] key2_q, key2_d; // second_lock_key_reg
   logic [7:0] syscfg_q, syscfg_d; // system_config_reg
   logic [7:0] strap_a_q, strap_a_d; // strap_config_reg_a
   logic [7:0] strap_b_q, strap_b_d; // strap_config_reg_b
   logic [7:0] strap_c_q, strap_c_d; // strap_config_reg_c
   logic [15:0] mode_q, mode_d; // subsystem_mode_reg
   logic [GIR_NSRC-1:0] en_q, en_d; // irq enables of irq_status_enable_reg
   logic vga_pend_q, vga_pend_d; // compatibility retrace pending
   logic vret_q; // previous retrace level
   logic [15:0] rdata_d; // next read data
   logic pin_d; // next pin level
   logic irq_want; // an interrupt is requested

   // decoded strobes
   logic wr_idx, wr_dat, rd_dat, ext_open, dat_open;
   logic wr_stat, wr_mode, vret_rise;
   logic [GIR_NSRC-1:0] status; // sticky extended status
   logic [GIR_NSRC-1:0] stat_clr; // write-one-to-clear mask

   // ==========================================================
   // decode of host accesses
   always_comb
   begin
      ext_open = syscfg_q[GIR_SYS_EXT_BIT];
      dat_open = idx_open(index_q, key1_q, key2_q);
      wr_idx = io_req.wr && io_req.addr == GIR_PORT_INDEX;
      wr_dat = io_req.wr && io_req.addr == GIR_PORT_DATA && dat_open;
      rd_dat = io_req.addr == GIR_PORT_DATA && dat_open;
      wr_stat = io_req.wr && io_req.addr == GIR_PORT_STAT_EN &&
                ext_open;
      wr_mode = io_req.wr && io_req.addr == GIR_PORT_SUBSYS && ext_open;
      stat_clr = wr_stat ? io_req.wdata[GIR_NSRC-1:0] : '0;
      vret_rise = evt.vretrace && !vret_q;
   end

   // sticky status of the four extended sources
   gir_sticky #(
      .N(GIR_NSRC)
   ) u_gir_sticky (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ev(evt),
      .clr(stat_clr),
      .status_q(status)
   );

   // ==========================================================
   // next register values, read mux and pin
   always_comb
   begin
      index_d = index_q;
      rctl_d = rctl_q;
      gctl_d = gctl_q;
      key1_d = key1_q;
      key2_d = key2_q;
      syscfg_d = syscfg_q;
      strap_a_d = strap_a_q;
      strap_b_d = strap_b_q;
      strap_c_d = strap_c_q;
      mode_d = mode_q;
      en_d = en_q;
      rdata_d = 16'h0000;
      // index port write
      if (wr_idx)
         index_d = io_req.wdata[7:0];
      // indexed data write, locked indices ignored
      if (wr_dat)
      begin
         case (index_q)
            GIR_IDX_RETRACE: rctl_d = io_req.wdata[7:0];
            GIR_IDX_GCTL: gctl_d = io_req.wdata[7:0];
            GIR_IDX_KEY1: key1_d = io_req.wdata[7:0];
            GIR_IDX_KEY2: key2_d = io_req.wdata[7:0];
            GIR_IDX_SYSCFG: syscfg_d = io_req.wdata[7:0];
            GIR_IDX_STRAP_A: strap_a_d = io_req.wdata[7:0];
            GIR_IDX_STRAP_B: strap_b_d = io_req.wdata[7:0];
            GIR_IDX_STRAP_C: strap_c_d = io_req.wdata[7:0];
            default: index_d = index_d;
         endcase
      end
      // enhanced port writes, enables in the high byte
      if (wr_stat)
         en_d = io_req.wdata[GIR_EN_LSB +: GIR_NSRC];
      if (wr_mode)
         mode_d = io_req.wdata;
      // read mux, locked or unmapped reads return zero
      if (io_req.addr == GIR_PORT_INDEX)
         rdata_d = {8'h00, index_q};
      else if (io_req.addr == GIR_PORT_STAT_EN && ext_open)
         rdata_d = {4'h0, en_q, 4'h0, status};
      else if (io_req.addr == GIR_PORT_SUBSYS && ext_open)
         rdata_d = mode_q;
      else if (rd_dat)
      begin
         case (index_q)
            GIR_IDX_RETRACE: rdata_d = {8'h00, rctl_q};
            GIR_IDX_GCTL: rdata_d = {8'h00, gctl_q};
            GIR_IDX_KEY1: rdata_d = {8'h00, key1_q};
            GIR_IDX_KEY2: rdata_d = {8'h00, key2_q};
            GIR_IDX_SYSCFG: rdata_d = {8'h00, syscfg_q};
            GIR_IDX_STRAP_A: rdata_d = {8'h00, strap_a_q};
            GIR_IDX_STRAP_B: rdata_d = {8'h00, strap_b_q};
            GIR_IDX_STRAP_C: rdata_d = {8'h00, strap_c_q};
            default: rdata_d = 16'h0000;
         endcase
      end
      // compatibility retrace: armed while bit4 set and bit5 clear
      vga_pend_d = vga_pend_q;
      if (vret_rise && rctl_q[GIR_RT_ARM_BIT] && !rctl_q[GIR_RT_DIS_BIT])
         vga_pend_d = 1'b1;
      if (!rctl_d[GIR_RT_ARM_BIT])
         vga_pend_d = 1'b0;
      // source selection by mode, gated by global enable
      if (mode_q[GIR_SUB_EXT_BIT])
         irq_want = |(status & en_q);
      else
         irq_want = vga_pend_q;
      irq_want = irq_want && gctl_q[GIR_GCTL_EN_BIT];
      // polarity from the bus type
      pin_d = bus_is_vlb ? irq_want : !irq_want;
   end

   // register everything
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         index_q <= GIR_RST_BYTE;
         rctl_q <= GIR_RST_BYTE;
         gctl_q <= GIR_RST_BYTE;
         key1_q <= GIR_RST_BYTE;
         key2_q <= GIR_RST_BYTE;
         syscfg_q <= GIR_RST_BYTE;
         strap_a_q <= GIR_RST_BYTE;
         strap_b_q <= GIR_RST_BYTE;
         strap_c_q <= GIR_RST_BYTE;
         mode_q <= GIR_RST_WORD;
         en_q <= '0;
         vga_pend_q <= 1'b0;
         vret_q <= 1'b0;
         io_rdata_q <= GIR_RST_WORD;
         io_rvalid_q <= 1'b0;
         irq_pin_q <= 1'b1;
      end
      else
      begin
         index_q <= index_d;
         rctl_q <= rctl_d;
         gctl_q <= gctl_d;
         key1_q <= key1_d;
         key2_q <= key2_d;
         syscfg_q <= syscfg_d;
         strap_a_q <= strap_a_d;
         strap_b_q <= strap_b_d;
         strap_c_q <= strap_c_d;
         mode_q <= mode_d;
         en_q <= en_d;
         vga_pend_q <= vga_pend_d;
         vret_q <= evt.vretrace;
         io_rdata_q <= rdata_d;
         io_rvalid_q <= io_req.rd;
         irq_pin_q <= pin_d;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_pci_low_level: assert property (
      irq_want && !bus_is_vlb |=> !irq_pin_q)
      else $error("pci interrupt not driven low");
   a_vlb_high_level: assert property (
      irq_want && bus_is_vlb |=> irq_pin_q)
      else $error("vl bus interrupt not driven high");
   a_global_gate: assert property (
      !gctl_q[GIR_GCTL_EN_BIT] |=> irq_pin_q == !$past(bus_is_vlb))
      else $error("interrupt raised with global enable off");
   a_compat_source: assert property (
      !mode_q[GIR_SUB_EXT_BIT] && !vga_pend_q |=>
      irq_pin_q == !$past(bus_is_vlb))
      else $error("non-retrace interrupt in compatibility mode");
   a_retrace_unarmed: assert property (
      !vga_pend_q && !(rctl_q[GIR_RT_ARM_BIT] &&
      !rctl_q[GIR_RT_DIS_BIT]) |=> !vga_pend_q)
      else $error("retrace pending while not armed");
   a_retrace_clear: assert property (
      wr_dat && index_q == GIR_IDX_RETRACE &&
      !io_req.wdata[GIR_RT_ARM_BIT] |=> !vga_pend_q [*2])
      else $error("retrace pending not cleared by zero write");
   a_ext_any_pend: assert property (
      mode_q[GIR_SUB_EXT_BIT] && gctl_q[GIR_GCTL_EN_BIT] &&
      |(status & en_q) |=> irq_pin_q == $past(bus_is_vlb))
      else $error("pin released while an enabled status is set");
   a_zero_keeps: assert property (
      !wr_stat || io_req.wdata[GIR_NSRC-1:0] == '0 |=>
      ($past(status) & ~status) == '0)
      else $error("status lost without a clearing write");
   a_key1_lock: assert property (
      io_req.wr && io_req.addr == GIR_PORT_DATA &&
      index_q == GIR_IDX_GCTL && !key1_open(key1_q) |=> $stable(gctl_q))
      else $error("global control written while first key locked");
   a_key2_lock: assert property (
      io_req.wr && io_req.addr == GIR_PORT_DATA &&
      index_q == GIR_IDX_SYSCFG && key2_q != GIR_KEY2_VAL |=>
      $stable(syscfg_q))
      else $error("system config written while second key locked");
   a_ext_lock: assert property (
      io_req.wr && io_req.addr == GIR_PORT_STAT_EN &&
      !syscfg_q[GIR_SYS_EXT_BIT] |=> $stable(en_q) &&
      ($past(status) & ~status) == '0)
      else $error("enhanced port written while locked");
   // a retrace edge always latches status bit 0, enabled or not
   a_event_latch: assert property (
      evt.vretrace && !vret_q |=> status[0])
      else $error("retrace status not latched");
   // status read returns the sticky bits in the low nibble
   a_status_read: assert property (
      io_req.rd && io_req.addr == GIR_PORT_STAT_EN && ext_open |=>
      io_rvalid_q && io_rdata_q[GIR_NSRC-1:0] == $past(status))
      else $error("status read does not match sticky bits");
   // an enabling write arms the retrace source enable
   a_enable_load: assert property (
      wr_stat && io_req.wdata[GIR_EN_LSB] |=> en_q[0])
      else $error("retrace enable not loaded");

   c_ext_irq: cover property (mode_q[GIR_SUB_EXT_BIT] && irq_want);
   c_vga_irq: cover property (!mode_q[GIR_SUB_EXT_BIT] && irq_want);
   c_unlocked: cover property (key2_q == GIR_KEY2_VAL && ext_open);
   c_w1c: cover property (wr_stat && |(status & stat_clr));
   c_two_pend: cover property (mode_q[GIR_SUB_EXT_BIT] &&
      $countones(status & en_q) > 1);

endmodule

// [logic/gir_pkg.sv]
// Purpose: shared constants and types of the graphics interrupt unit
// Assumes: byte-wide indexed registers behind an index/data port pair
// Notes: enhanced ports are 16 bits wide, indexed registers 8 bits wide

package gir_pkg;

   // ==========================================================
   // i/o port addresses
   localparam logic [15:0] GIR_PORT_INDEX = 16'h03D4; // index port
   localparam logic [15:0] GIR_PORT_DATA = 16'h03D5; // data port
   localparam logic [15:0] GIR_PORT_STAT_EN = 16'h42E8; // status/enable
   localparam logic [15:0] GIR_PORT_SUBSYS = 16'h4AE8; // subsystem mode

   // ==========================================================
   // register indices behind the data port
   localparam logic [7:0] GIR_IDX_RETRACE = 8'h11; // retrace control
   localparam logic [7:0] GIR_IDX_GCTL = 8'h32; // global irq control
   localparam logic [7:0] GIR_IDX_STRAP_A = 8'h36; // strap config a
   localparam logic [7:0] GIR_IDX_STRAP_B = 8'h37; // strap config b
   localparam logic [7:0] GIR_IDX_KEY1 = 8'h38; // first lock key
   localparam logic [7:0] GIR_IDX_KEY2 = 8'h39; // second lock key
   localparam logic [7:0] GIR_IDX_SYSCFG = 8'h40; // system config
   localparam logic [7:0] GIR_IDX_STRAP_C = 8'h68; // strap config c
   localparam logic [7:0] GIR_IDX_EXT1_LO = 8'h30; // key1 range start
   localparam logic [7:0] GIR_IDX_EXT1_HI = 8'h3F; // key1 range end
   localparam logic [7:0] GIR_IDX_EXT2_LO = 8'h40; // key2 range start

   // ==========================================================
   // lock key patterns
   localparam logic [7:0] GIR_KEY1_MASK = 8'hCC; // significant bits
   localparam logic [7:0] GIR_KEY1_VAL = 8'h48; // 01xx10xx
   localparam logic [7:0] GIR_KEY2_VAL = 8'hA5; // exact code

   // ==========================================================
   // field positions
   localparam int GIR_GCTL_EN_BIT = 4; // global irq enable
   localparam int GIR_RT_ARM_BIT = 4; // retrace irq arm / clear
   localparam int GIR_RT_DIS_BIT = 5; // retrace irq disable
   localparam int GIR_SUB_EXT_BIT = 0; // extended mode select
   localparam int GIR_SYS_EXT_BIT = 0; // enhanced register access
   localparam int GIR_EN_LSB = 8; // enables in bits 11:8
   localparam int GIR_NSRC = 4; // number of extended sources

   // ==========================================================
   // reset values
   localparam logic [7:0] GIR_RST_BYTE = 8'h00; // indexed registers
   localparam logic [15:0] GIR_RST_WORD = 16'h0000; // enhanced ports

   // extended event sources, msb first in status order
   typedef struct packed {
      logic fifo_empty; // command fifo drained
      logic fifo_overflow; // command fifo overrun
      logic engine_busy; // drawing_engine busy
      logic vretrace; // vertical retrace
   } gir_evt_t;

   // host i/o request, one cycle per access
   typedef struct packed {
      logic [15:0] addr; // i/o address
      logic [15:0] wdata; // write data
      logic wr; // write strobe
      logic rd; // read strobe
   } gir_io_req_t;

endpackage

// [logic/gir_sticky.sv]
// Purpose: sticky status bits set on source rising edges
// Assumes: event inputs synchronous to core_clk
// Notes: a set in the same cycle as a clear wins

`timescale 1ns/1ps

module gir_sticky
   import gir_pkg::*;
#(
   parameter int N = GIR_NSRC
)
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [N-1:0] ev,
   input wire logic [N-1:0] clr,
   output logic [N-1:0] status_q
);

   // ==========================================================
   // state
   logic [N-1:0] ev_q; // previous event level
   logic [N-1:0] status_d; // next status

   // set on rising edge, clear by write-one, set wins
   always_comb
   begin
      status_d = (status_q & ~clr) | (ev & ~ev_q);
   end

   // register state
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ev_q <= '0;
         status_q <= '0;
      end
      else
      begin
         ev_q <= ev;
         status_q <= status_d;
      end
   end

endmodule

// [sim/gir_host_model.sv]
// Purpose: host side of the interrupt pin
// Assumes: pin level follows the bus type
// Notes: a request is seen as a plain level
`timescale 1ns/1ps

module gir_host_model
   import gir_pkg::*;
(
   input wire logic bus_is_vlb,
   input wire logic irq_pin,
   output logic irq_seen
);
   // ==========================================
   // decode pin polarity to a request level
   always_comb
   begin
      irq_seen = bus_is_vlb ? irq_pin : !irq_pin;
   end
endmodule

// [sim/gir_top_tb.sv]
// Purpose: self-checking bench of gir_top
// Assumes: host drives io_req at falling edges
// Notes: pin checked raw and through the host model
`timescale 1ns/1ps

module gir_top_tb
   import gir_pkg::*;
;
   // ==========================================
   // stimulus and observed signals
   localparam logic [15:0] SE = GIR_PORT_STAT_EN; // short alias
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic bus_is_vlb = 1'b0;
   logic [3:0] ev = 4'h0; // event levels
   gir_io_req_t io_req = '0;
   logic [15:0] io_rdata_q;
   logic io_rvalid_q;
   logic irq_pin_q;
   logic irq_seen; // decoded by host model
   logic [15:0] d; // last read data
   int errors = 0;
   int total_checks = 0;

   // clock at 50 MHz
   always #10 core_clk = ~core_clk;

   gir_top u_gir_top (.core_clk(core_clk), .rst_n(rst_n),
      .bus_is_vlb(bus_is_vlb), .evt(gir_evt_t'(ev)), .io_req(io_req),
      .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
      .irq_pin_q(irq_pin_q));
   gir_host_model u_gir_host_model (.bus_is_vlb(bus_is_vlb),
      .irq_pin(irq_pin_q), .irq_seen(irq_seen));

   // ==========================================
   // compare and report
   task automatic chk16(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      total_checks++;
      if (g !== e)
      begin
         errors++;
         $display("Error %s exp %b got %b", nm, e, g);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ==========================================
   // host access tasks, one strobe cycle each
   task automatic settle();
      repeat (3) @(negedge core_clk);
   endtask

   task automatic io_wr(input logic [15:0] a, input logic [15:0] w);
      @(negedge core_clk);
      io_req = '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
      @(negedge core_clk);
      io_req = '0;
   endtask

   // data is taken the cycle after the strobe
   task automatic io_rd(input logic [15:0] a);
      @(negedge core_clk);
      io_req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(negedge core_clk);
      io_req = '0;
      d = (io_rvalid_q === 1'b1) ? io_rdata_q : 16'hXXXX;
   endtask

   // indexed register write and read
   task automatic crw(input logic [7:0] idx, input logic [7:0] v);
      io_wr(GIR_PORT_INDEX, {8'h00, idx});
      io_wr(GIR_PORT_DATA, {8'h00, v});
   endtask

   task automatic crr(input logic [7:0] idx);
      io_wr(GIR_PORT_INDEX, {8'h00, idx});
      io_rd(GIR_PORT_DATA);
   endtask

   // one-cycle event, then wait for the pin
   task automatic pulse(input logic [3:0] m);
      @(negedge core_clk);
      ev = m;
      @(negedge core_clk);
      ev = 4'h0;
      settle();
   endtask

   // pin level expected for a request state
   task automatic pin(input logic act);
      chk1("irq_pin", bus_is_vlb ? act : ~act, irq_pin_q);
      chk1("irq_seen", act, irq_seen);
   endtask

   // ==========================================
   // watchdog, far beyond the test length
   initial
   begin
      #400000;
      errors++;
      finish_test();
   end

   // ==========================================
   // test sequence
   initial
   begin
      repeat (2) @(negedge core_clk);
      rst_n = 1'b1;
      @(negedge core_clk);
      pin(1'b0);
      // lock gating
      io_wr(SE, 16'h0F00);
      io_rd(SE);
      chk16("se_locked", 16'h0000, d);
      crw(GIR_IDX_GCTL, 8'h10);
      crr(GIR_IDX_GCTL);
      chk16("gctl_locked", 16'h0000, d);
      crw(GIR_IDX_KEY1, 8'h7B);
      crw(GIR_IDX_GCTL, 8'h10);
      crr(GIR_IDX_GCTL);
      chk16("gctl_open", 16'h0010, d);
      crw(GIR_IDX_SYSCFG, 8'h6C);
      crr(GIR_IDX_SYSCFG);
      chk16("syscfg_locked", 16'h0000, d);
      crw(GIR_IDX_KEY2, 8'hA5);
      crw(GIR_IDX_STRAP_C, 8'h5A);
      crr(GIR_IDX_STRAP_C);
      chk16("strap_c", 16'h005A, d);
      crw(GIR_IDX_SYSCFG, 8'h6C);
      crr(GIR_IDX_SYSCFG);
      crw(GIR_IDX_SYSCFG, d[7:0] | 8'h01);
      crr(GIR_IDX_SYSCFG);
      chk16("syscfg_rmw", 16'h006D, d);
      // unmapped index reads as zero
      crw(8'h20, 8'hFF);
      crr(8'h20);
      chk16("unmapped", 16'h0000, d);
      $display("test unlock done");
      // extended mode, each source alone
      io_wr(GIR_PORT_SUBSYS, 16'h0001);
      io_wr(SE, 16'h0F00);
      for (int i = 0; i < 4; i++)
      begin
         pulse(4'h1 << i);
         io_rd(SE);
         chk16("se_set", 16'h0F00 | (16'h1 << i), d);
         pin(1'b1);
         io_wr(SE, 16'h0F00);
         io_rd(SE);
         chk16("se_w0", 16'h0F00 | (16'h1 << i), d);
         io_wr(SE, 16'h0F00 | (16'h1 << i));
         settle();
         io_rd(SE);
         chk16("se_w1c", 16'h0F00, d);
         pin(1'b0);
      end
      // two pending, released only when both clear
      pulse(4'h5);
      io_wr(SE, 16'h0F01);
      settle();
      pin(1'b1);
      io_wr(SE, 16'h0F04);
      settle();
      pin(1'b0);
      // disabled source still latches
      io_wr(SE, 16'h0E00);
      pulse(4'h1);
      io_rd(SE);
      chk16("se_masked", 16'h0E01, d);
      pin(1'b0);
      io_wr(SE, 16'h0F00);
      settle();
      pin(1'b1);
      crw(GIR_IDX_GCTL, 8'h00);
      settle();
      pin(1'b0);
      bus_is_vlb = 1'b1;
      settle();
      pin(1'b0);
      crw(GIR_IDX_GCTL, 8'h10);
      settle();
      pin(1'b1);
      io_wr(SE, 16'h0F01);
      settle();
      pin(1'b0);
      bus_is_vlb = 1'b0;
      $display("test extended done");
      // compatibility mode, retrace only
      io_wr(GIR_PORT_SUBSYS, 16'h0000);
      pulse(4'hE);
      pin(1'b0);
      pulse(4'h1);
      pin(1'b0);
      crw(GIR_IDX_RETRACE, 8'h10);
      pulse(4'h1);
      pin(1'b1);
      crw(GIR_IDX_RETRACE, 8'h00);
      settle();
      pin(1'b0);
      crw(GIR_IDX_RETRACE, 8'h10);
      settle();
      pin(1'b0);
      pulse(4'h1);
      pin(1'b1);
      crw(GIR_IDX_RETRACE, 8'h00);
      crw(GIR_IDX_RETRACE, 8'h30);
      pulse(4'h1);
      pin(1'b0);
      $display("test compat done");
      finish_test();
   end
endmodule
